// ===== pstd_defs.svh
// Constants for the self-test sequencer and remote diagnostic interpreter.
// Assumes a 125 MHz clock.
`ifndef PSTD_DEFS_SVH
`define PSTD_DEFS_SVH

// ******************************************
// Character codes
// ******************************************
`define PSTD_CH_ESC 8'h1B
`define PSTD_CH_SUB 8'h1A
`define PSTD_CH_INIT 8'h49
`define PSTD_CH_ERST 8'h52
`define PSTD_CH_STAT 8'h31
`define PSTD_CH_SO 8'h0E
`define PSTD_CH_ENQ 8'h05
`define PSTD_CH_STX 8'h02
`define PSTD_CH_ACK 8'h06
`define PSTD_CH_CR 8'h0D
`define PSTD_CH_LF 8'h0A
`define PSTD_CH_DEL 8'h7F
`define PSTD_CH_RD 8'h28
`define PSTD_CH_TA 8'h41
`define PSTD_CH_TB 8'h42
`define PSTD_CH_TC 8'h43
`define PSTD_CH_TD 8'h44
`define PSTD_CH_SP 8'h20
`define PSTD_CH_TOP 8'h7E

// ******************************************
// Counts, bit positions, addresses, CRC polynomial and timing
// ******************************************
`define PSTD_SWIRL_LINES 7'h62
`define PSTD_LINE_CHARS 8'h84
`define PSTD_WHEEL_ADDR 8'h22
`define PSTD_ST_PITCH10 1
`define PSTD_ST_IDLE 5
`define PSTD_ST_PAR 7
`define PSTD_RES_AUXRAM 0
`define PSTD_RES_AUXROM 1
`define PSTD_RES_RAM 2
`define PSTD_RES_ROMHI 3
`define PSTD_RES_ROMLO 4
`define PSTD_PITCH_TEN 3'h7
`define PSTD_CRC_POLY 16'h8005
`define PSTD_ROM_HALF 12'h800
`define PSTD_ERST_MS 250
`define PSTD_CLK_KHZ 125000
`define PSTD_ERST_CYC (`PSTD_ERST_MS * `PSTD_CLK_KHZ)

`endif

// ===== pstd_pkg.sv
// Types for the self-test sequencer and diagnostic interpreter.
// Assumes nothing else.
package pstd_pkg;
  // Main sequencer states
  typedef enum logic [4:0] {
    PSTD_IDLE, PSTD_SIGNON, PSTD_ROM, PSTD_ROMRPT, PSTD_RAMRD, PSTD_RAMWR,
    PSTD_RAMCHK, PSTD_RAMRPT, PSTD_SWIRL, PSTD_RESULT, PSTD_DRAIN, PSTD_TSTENT,
    PSTD_TEST, PSTD_RDADR, PSTD_RDREP, PSTD_CRLF, PSTD_ACKS, PSTD_DONE
  } pstd_state_t;
  // Command parser states
  typedef enum logic [1:0] {PSTD_P_IDLE, PSTD_P_ESC, PSTD_P_SUB} pstd_parse_t;
endpackage

// ===== pstd_selftest.sv
// Self-test sequencer and remote diagnostic command interpreter.
// Assumes byte-wide ports, with ready on transmit and print only,
// and one-cycle ROM and RAM reads.
`timescale 1ns/1ps
`include "pstd_defs.svh"

module pstd_selftest
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Triggers and status from the printer
  input wire logic selftest_start_in,
  input wire logic printer_idle_in,
  input wire logic error_pending_in,
  input wire logic [7:0] wheel_info_in,
  input wire logic aux_ram_bad_in,
  input wire logic aux_rom_bad_in,
  input wire logic parity_bit_in,
  // Received bytes from the serial link
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  // Transmitted bytes to the host
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  input wire logic tx_ready_in,
  // Printed characters to the print engine
  output logic prt_valid_out,
  output logic [7:0] prt_data_out,
  input wire logic prt_ready_in,
  // Report codes: 0 none,1 sign-on,2 romok,3 rombad,4 ramok,5 rambad
  output logic [2:0] report_out,
  // ROM read port, data one cycle after address
  output logic [11:0] rom_addr_out,
  input wire logic [7:0] rom_data_in,
  // RAM port, data one cycle after address
  output logic [7:0] ram_addr_out,
  output logic ram_we_out,
  output logic [7:0] ram_wdata_out,
  input wire logic [7:0] ram_rdata_in,
  // Controls to the printer
  output logic init_out,
  output logic err_reset_out,
  output logic stop_motion_out,
  output logic test_mode_out,
  output logic busy_out
);

  // ******************************************
  // Declarations
  // ******************************************
  pstd_pkg::pstd_state_t state; // Sequencer state
  pstd_pkg::pstd_parse_t pstate; // Escape parser state
  logic remote; // Memory test started remotely
  logic [15:0] crc; // CRC remainder
  logic [11:0] rom_idx; // Bytes left in ROM walk
  logic [3:0] bit_idx; // CRC bit counter
  logic [7:0] rom_byte; // Byte under division
  logic rom_phase; // Waiting on ROM read data
  logic rom_hi_bad; // Upper half fault
  logic rom_lo_bad; // Lower half fault
  logic [7:0] ram_idx; // RAM location under test
  logic [7:0] ram_save; // Saved contents
  logic [3:0] ram_bit; // Bit under test, 8 means restore
  logic ram_set; // Writing set (1) or clear (0)
  logic ram_bad; // Any RAM fault
  logic [6:0] line_cnt; // Swirl lines left
  logic [7:0] char_cnt; // Characters printed in line
  logic [7:0] rot; // Line starting character
  logic [7:0] cur_ch; // Current swirl character
  logic continuous; // Byte C mode
  logic one_line; // Byte B mode
  logic crlf_sel; // Second character of CR LF
  logic [31:0] erst_cnt; // Error reset hold counter
  logic [7:0] reply; // Byte to send on reply
  logic [7:0] rd_data; // Latched RAM read

  // Wraps within printable range
  function automatic logic [7:0] next_char(input logic [7:0] c);
    next_char = (c == `PSTD_CH_TOP) ? `PSTD_CH_SP + 8'h01 : c + 8'h01;
  endfunction

  // One CRC-16 shift step, MSB first
  function automatic logic [15:0] crc_step(input logic [15:0] r, input logic b);
    crc_step = (r[15] ^ b) ? ({r[14:0], 1'b0} ^ `PSTD_CRC_POLY) : {r[14:0], 1'b0};
  endfunction

  // Status word
  function automatic logic [7:0] status_word(input logic [7:0] w, input logic idle,
                                             input logic par);
    status_word = 8'h00;
    status_word[`PSTD_ST_PITCH10] = (w[2:0] == `PSTD_PITCH_TEN);
    status_word[`PSTD_ST_IDLE] = idle;
    status_word[`PSTD_ST_PAR] = par;
  endfunction

  // ******************************************
  // Escape command parser
  // ******************************************
  // Tracks ESC SUB prefix in every state but PSTD_TEST
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      pstate <= pstd_pkg::PSTD_P_IDLE;
    else if (rx_valid_in && state != pstd_pkg::PSTD_TEST)
    begin
      case (pstate)
        pstd_pkg::PSTD_P_IDLE:
          pstate <= (rx_data_in == `PSTD_CH_ESC) ? pstd_pkg::PSTD_P_ESC : pstd_pkg::PSTD_P_IDLE;
        pstd_pkg::PSTD_P_ESC:
          pstate <= (rx_data_in == `PSTD_CH_SUB) ? pstd_pkg::PSTD_P_SUB : pstd_pkg::PSTD_P_IDLE;
        default:
          pstate <= pstd_pkg::PSTD_P_IDLE;
      endcase
    end
  end

  logic cmd_hit; // Third byte of a diagnostic command
  assign cmd_hit = rx_valid_in && pstate == pstd_pkg::PSTD_P_SUB;

  // ******************************************
  // Error reset hold
  // ******************************************
  // Holds error reset while settling
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      erst_cnt <= 32'h0;
    else if (cmd_hit && rx_data_in == `PSTD_CH_ERST)
      erst_cnt <= 32'(`PSTD_ERST_CYC);
    else if (erst_cnt != 32'h0)
      erst_cnt <= erst_cnt - 32'h1;
  end
  assign err_reset_out = (erst_cnt != 32'h0);

  // ******************************************
  // Main sequencer
  // ******************************************
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state <= pstd_pkg::PSTD_IDLE;
      remote <= 1'b0;
      crc <= 16'h0;
      rom_idx <= 12'h0;
      bit_idx <= 4'h0;
      rom_byte <= 8'h0;
      rom_phase <= 1'b0;
      rom_hi_bad <= 1'b0;
      rom_lo_bad <= 1'b0;
      ram_idx <= 8'h0;
      ram_save <= 8'h0;
      ram_bit <= 4'h0;
      ram_set <= 1'b0;
      ram_bad <= 1'b0;
      line_cnt <= 7'h0;
      char_cnt <= 8'h0;
      rot <= `PSTD_CH_SP;
      cur_ch <= `PSTD_CH_SP;
      continuous <= 1'b0;
      one_line <= 1'b0;
      crlf_sel <= 1'b0;
      reply <= 8'h0;
      rd_data <= 8'h0;
      init_out <= 1'b0;
    end
    else
    begin
      init_out <= 1'b0;
      if (cmd_hit && rx_data_in == `PSTD_CH_INIT)
      begin
        // Overrides every state but PSTD_TEST, errors included
        init_out <= 1'b1;
        state <= pstd_pkg::PSTD_IDLE;
        continuous <= 1'b0;
        one_line <= 1'b0;
      end
      else
      begin
        case (state)
          pstd_pkg::PSTD_IDLE:
          begin
            if (cmd_hit && rx_data_in == `PSTD_CH_STAT)
            begin
              reply <= status_word(wheel_info_in, printer_idle_in, parity_bit_in);
              state <= pstd_pkg::PSTD_ACKS;
            end
            else if (cmd_hit && rx_data_in == `PSTD_CH_SO)
            begin
              // Remote test runs RAM then ROM, no printout
              remote <= 1'b1;
              ram_idx <= 8'h0;
              ram_bit <= 4'h0;
              ram_bad <= 1'b0;
              state <= pstd_pkg::PSTD_RAMRD;
            end
            else if (cmd_hit && rx_data_in == `PSTD_CH_ENQ)
              state <= pstd_pkg::PSTD_DRAIN;
            else if (selftest_start_in)
            begin
              remote <= 1'b0;
              state <= pstd_pkg::PSTD_SIGNON;
            end
          end
          pstd_pkg::PSTD_SIGNON:
          begin
            // Sign-on opens local test
            crc <= 16'h0;
            rom_idx <= 12'hFFF;
            rom_phase <= 1'b0;
            bit_idx <= 4'h0;
            rom_hi_bad <= 1'b0;
            rom_lo_bad <= 1'b0;
            state <= pstd_pkg::PSTD_ROM;
          end
          pstd_pkg::PSTD_ROM:
          begin
            // Last byte down, MSB first
            if (!rom_phase)
            begin
              rom_phase <= 1'b1;
              bit_idx <= 4'h8;
            end
            else if (bit_idx == 4'h8)
            begin
              rom_byte <= rom_data_in;
              bit_idx <= 4'h7;
            end
            else
            begin
              crc <= crc_step(crc, rom_byte[bit_idx[2:0]]);
              if (bit_idx != 4'h0)
                bit_idx <= bit_idx - 4'h1;
              else if (rom_idx == `PSTD_ROM_HALF)
              begin
                // Upper half on its own
                rom_hi_bad <= (crc_step(crc, rom_byte[0]) != 16'h0);
                crc <= 16'h0;
                rom_idx <= rom_idx - 12'h1;
                rom_phase <= 1'b0;
              end
              else if (rom_idx == 12'h0)
              begin
                rom_lo_bad <= (crc_step(crc, rom_byte[0]) != 16'h0);
                state <= remote ? pstd_pkg::PSTD_RESULT : pstd_pkg::PSTD_ROMRPT;
              end
              else
              begin
                rom_idx <= rom_idx - 12'h1;
                rom_phase <= 1'b0;
              end
            end
          end
          pstd_pkg::PSTD_ROMRPT:
          begin
            // One-cycle report; RAM next
            ram_idx <= 8'h0;
            ram_bit <= 4'h0;
            ram_bad <= 1'b0;
            state <= pstd_pkg::PSTD_RAMRD;
          end
          pstd_pkg::PSTD_RAMRD:
            state <= pstd_pkg::PSTD_RAMWR;
          pstd_pkg::PSTD_RAMWR:
          begin
            // First visit saves contents
            if (ram_bit == 4'h0 && !ram_set)
              ram_save <= ram_rdata_in;
            state <= pstd_pkg::PSTD_RAMCHK;
          end
          pstd_pkg::PSTD_RAMCHK:
          begin
            // Reads back the pattern just written
            if (ram_bit != 4'h8 && ram_rdata_in[ram_bit[2:0]] != ram_set)
              ram_bad <= 1'b1;
            if (ram_bit == 4'h8)
            begin
              ram_bit <= 4'h0;
              ram_set <= 1'b0;
              if (ram_idx == 8'hFF)
                state <= remote ? pstd_pkg::PSTD_ROM : pstd_pkg::PSTD_RAMRPT;
              else
              begin
                ram_idx <= ram_idx + 8'h1;
                state <= pstd_pkg::PSTD_RAMRD;
              end
              if (ram_idx == 8'hFF && remote)
              begin
                crc <= 16'h0;
                rom_idx <= 12'hFFF;
                rom_phase <= 1'b0;
                rom_hi_bad <= 1'b0;
                rom_lo_bad <= 1'b0;
              end
            end
            else
            begin
              if (ram_set)
                ram_bit <= ram_bit + 4'h1;
              ram_set <= !ram_set;
              state <= pstd_pkg::PSTD_RAMWR;
            end
          end
          pstd_pkg::PSTD_RAMRPT:
          begin
            // RAM fault stops here, ROM fault skips swirl
            if (ram_bad)
              state <= pstd_pkg::PSTD_IDLE;
            else if (rom_hi_bad || rom_lo_bad)
              state <= pstd_pkg::PSTD_IDLE;
            else
            begin
              line_cnt <= `PSTD_SWIRL_LINES;
              char_cnt <= 8'h0;
              rot <= `PSTD_CH_SP + 8'h01;
              cur_ch <= `PSTD_CH_SP + 8'h01;
              state <= pstd_pkg::PSTD_SWIRL;
            end
          end
          pstd_pkg::PSTD_SWIRL:
          begin
            if (rx_valid_in && rx_data_in == `PSTD_CH_TD && (continuous || one_line))
            begin
              // Immediate stop then line end
              continuous <= 1'b0;
              one_line <= 1'b0;
              crlf_sel <= 1'b0;
              reply <= `PSTD_CH_ACK;
              state <= pstd_pkg::PSTD_CRLF;
            end
            else if (prt_ready_in)
            begin
              if (char_cnt == `PSTD_LINE_CHARS - 8'h01)
              begin
                // Line done; next line rotates by one
                char_cnt <= 8'h0;
                rot <= next_char(rot);
                cur_ch <= next_char(rot);
                if (one_line)
                begin
                  one_line <= 1'b0;
                  reply <= `PSTD_CH_ACK;
                  state <= pstd_pkg::PSTD_ACKS;
                end
                else if (!continuous)
                begin
                  line_cnt <= line_cnt - 7'h1;
                  if (line_cnt == 7'h1)
                    state <= pstd_pkg::PSTD_IDLE;
                end
              end
              else
              begin
                char_cnt <= char_cnt + 8'h1;
                cur_ch <= next_char(cur_ch);
              end
            end
          end
          pstd_pkg::PSTD_RESULT:
          begin
            // Result byte: fault flags and parity
            reply <= {parity_bit_in, 2'b00, rom_lo_bad, rom_hi_bad, ram_bad,
                      aux_rom_bad_in, aux_ram_bad_in};
            state <= pstd_pkg::PSTD_ACKS;
          end
          pstd_pkg::PSTD_DRAIN:
          begin
            // Drain buffered bytes first
            if (printer_idle_in)
            begin
              reply <= `PSTD_CH_SO;
              state <= pstd_pkg::PSTD_TSTENT;
            end
          end
          pstd_pkg::PSTD_TSTENT:
            if (tx_ready_in)
              state <= pstd_pkg::PSTD_TEST;
          pstd_pkg::PSTD_TEST:
          begin
            if (rx_valid_in)
            begin
              case (rx_data_in)
                `PSTD_CH_RD: state <= pstd_pkg::PSTD_RDADR;
                `PSTD_CH_TA:
                begin
                  remote <= 1'b1;
                  ram_idx <= 8'h0;
                  ram_bit <= 4'h0;
                  ram_bad <= 1'b0;
                  state <= pstd_pkg::PSTD_RAMRD;
                end
                `PSTD_CH_TB:
                begin
                  one_line <= 1'b1;
                  char_cnt <= 8'h0;
                  cur_ch <= rot;
                  state <= pstd_pkg::PSTD_SWIRL;
                end
                `PSTD_CH_TC:
                begin
                  continuous <= 1'b1;
                  char_cnt <= 8'h0;
                  cur_ch <= rot;
                  state <= pstd_pkg::PSTD_SWIRL;
                end
                `PSTD_CH_DEL:
                begin
                  init_out <= 1'b1;
                  state <= pstd_pkg::PSTD_IDLE;
                end
                default: state <= pstd_pkg::PSTD_TEST;
              endcase
            end
          end
          pstd_pkg::PSTD_RDADR:
            if (rx_valid_in)
              state <= pstd_pkg::PSTD_RDREP;
          pstd_pkg::PSTD_RDREP:
          begin
            // STX, then latched byte
            rd_data <= ram_rdata_in;
            reply <= `PSTD_CH_STX;
            crlf_sel <= 1'b1;
            state <= pstd_pkg::PSTD_ACKS;
          end
          pstd_pkg::PSTD_CRLF:
            if (prt_ready_in)
            begin
              crlf_sel <= !crlf_sel;
              if (crlf_sel)
                state <= pstd_pkg::PSTD_ACKS;
            end
          pstd_pkg::PSTD_ACKS:
          begin
            // Sends reply; memory read sends a second byte
            if (tx_ready_in)
            begin
              if (reply == `PSTD_CH_STX && crlf_sel)
              begin
                reply <= rd_data;
                crlf_sel <= 1'b0;
              end
              else
              begin
                state <= test_mode_out ? pstd_pkg::PSTD_TEST : pstd_pkg::PSTD_IDLE;
                remote <= 1'b0;
              end
            end
          end
          default: state <= pstd_pkg::PSTD_IDLE;
        endcase
      end
    end
  end

  // ******************************************
  // Test mode flag
  // ******************************************
  // Set on entry, cleared by init
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      test_mode_out <= 1'b0;
    else if (state == pstd_pkg::PSTD_TSTENT)
      test_mode_out <= 1'b1;
    else if (init_out || (cmd_hit && rx_data_in == `PSTD_CH_INIT))
      test_mode_out <= 1'b0;
  end

  // ******************************************
  // Output decode
  // ******************************************
  always_comb
  begin
    tx_valid_out = (state == pstd_pkg::PSTD_ACKS) || (state == pstd_pkg::PSTD_TSTENT);
    tx_data_out = reply;
    prt_valid_out = (state == pstd_pkg::PSTD_SWIRL) || (state == pstd_pkg::PSTD_CRLF);
    prt_data_out = (state == pstd_pkg::PSTD_CRLF) ?
                   (crlf_sel ? `PSTD_CH_LF : `PSTD_CH_CR) : cur_ch;
    report_out = 3'h0;
    if (state == pstd_pkg::PSTD_SIGNON)
      report_out = 3'h1;
    else if (state == pstd_pkg::PSTD_ROMRPT)
      report_out = (rom_hi_bad || rom_lo_bad) ? 3'h3 : 3'h2;
    else if (state == pstd_pkg::PSTD_RAMRPT)
      report_out = ram_bad ? 3'h5 : 3'h4;
    rom_addr_out = rom_idx;
    ram_addr_out = ram_idx;
    if (state == pstd_pkg::PSTD_RDADR)
      ram_addr_out = rx_data_in;
    ram_we_out = (state == pstd_pkg::PSTD_RAMWR);
    ram_wdata_out = (ram_bit == 4'h8) ? ram_save :
                    (ram_set ? (ram_save | (8'h01 << ram_bit[2:0]))
                             : (ram_save & ~(8'h01 << ram_bit[2:0])));
    stop_motion_out = (state == pstd_pkg::PSTD_TSTENT) || (state == pstd_pkg::PSTD_TEST);
    busy_out = (state != pstd_pkg::PSTD_IDLE) && (state != pstd_pkg::PSTD_TEST);
  end

endmodule

// ===== pstd_host_model.sv
// Host-side model: sends command bytes and takes replies with stalls.
// Assumes bytes sampled on rising edges.
`timescale 1ns/1ps
module pstd_host_model
(
  // Clock
  input wire logic clk_in,
  // Bytes to the block
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  // Replies from the block
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out
);
  logic [7:0] got[$]; // Replies in arrival order
  logic [1:0] pace = 2'h0; // Stall pattern count
  initial
  begin
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
    tx_ready_out = 1'b0;
  end
  // Ready three cycles in four
  always @(posedge clk_in)
  begin
    pace <= pace + 2'h1;
    tx_ready_out <= (pace != 2'h3);
    if (tx_valid_in === 1'b1 && tx_ready_out)
      got.push_back(tx_data_in);
  end
  // One byte per cycle
  task send(input logic [7:0] b);
    @(posedge clk_in);
    rx_valid_out <= 1'b1;
    rx_data_out <= b;
  endtask
  // Released data flips
  task idle();
    @(posedge clk_in);
    rx_valid_out <= 1'b0;
    rx_data_out <= ~rx_data_out;
  endtask
endmodule

// ===== pstd_selftest_properties.sv
// Assertions on the self-test and diagnostic interpreter ports.
// Assumes the top module's port names.
`timescale 1ns/1ps
`include "pstd_defs.svh"
module pstd_selftest_properties
(
  // Clock, reset and inputs
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic [7:0] wheel_info_in,
  input wire logic tx_ready_in,
  // Observed outputs
  input wire logic tx_valid_out,
  input wire logic [7:0] tx_data_out,
  input wire logic prt_valid_out,
  input wire logic [7:0] prt_data_out,
  input wire logic [2:0] report_out,
  input wire logic init_out,
  input wire logic err_reset_out,
  input wire logic test_mode_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // ****************************************
  // Command framing
  // ****************************************
  function automatic logic rx_is(logic [7:0] c);
    return rx_valid_in && rx_data_in == c;
  endfunction
  sequence esc_sub(logic [7:0] c);
    !test_mode_out && rx_is(`PSTD_CH_ESC) ##1 rx_is(`PSTD_CH_SUB) ##1 rx_is(c);
  endsequence
  chk_tx_holds: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
    else $error("reply dropped before taken");
  chk_status_byte: assert property (esc_sub(`PSTD_CH_STAT) |-> ##[1:8] tx_valid_out
    && tx_data_out[6:0] == {1'b0, tx_data_out[5], 3'h0, wheel_info_in[2:0] == 3'h7, 1'b0})
    else $error("status byte wrong");
  chk_init_pulse: assert property (esc_sub(`PSTD_CH_INIT) |-> ##[1:3] init_out)
    else $error("initialize not issued");
  chk_err_reset: assert property (esc_sub(`PSTD_CH_ERST) |-> ##[1:3] err_reset_out)
    else $error("error reset not issued");
  chk_test_entry: assert property (esc_sub(`PSTD_CH_ENQ) |-> ##[1:200] tx_valid_out && tx_data_out == `PSTD_CH_SO)
    else $error("test mode entry not signalled");
  chk_mem_read: assert property (test_mode_out && rx_is(`PSTD_CH_RD) ##1 rx_is(`PSTD_WHEEL_ADDR)
    |-> ##[1:20] tx_valid_out && tx_data_out == `PSTD_CH_STX)
    else $error("memory read reply missing");
  chk_ignore_byte: assert property (test_mode_out && rx_is(8'h5A) |=> (test_mode_out && !tx_valid_out)[*4])
    else $error("unknown test byte acted on");
  chk_leave_test: assert property (test_mode_out && rx_is(`PSTD_CH_DEL) |-> ##[1:4] !test_mode_out)
    else $error("test mode not left");
  chk_no_swirl: assert property (report_out == 3'h5 |=> (!prt_valid_out)[*8])
    else $error("printing after memory fault");
  chk_swirl_char: assert property (prt_valid_out |-> prt_data_out inside {[`PSTD_CH_SP:`PSTD_CH_TOP],
    `PSTD_CH_CR, `PSTD_CH_LF})
    else $error("printed byte out of range");
endmodule

// ===== pstd_selftest_tb.sv
// Self-checking bench for the self-test and diagnostic interpreter.
// Assumes the host model and checker.
`timescale 1ns/1ps
`include "pstd_defs.svh"
module pstd_selftest_tb;
  logic clk_in = 1'b0, rst_n_in = 1'b0, selftest_start_in, printer_idle_in, error_pending_in;
  logic aux_ram_bad_in, aux_rom_bad_in, parity_bit_in, rom_bad, ram_bad;
  logic [7:0] wheel_info_in, rom_data_in, ram_rdata_in, b, keep, last1, last2;
  logic [7:0] mem [256]; // RAM model
  logic [31:0] seed = 32'h00000D46; // Fixed start 3398
  logic [2:0] reps[$]; // Report codes seen
  int miscompares = 0, check_count = 0, nchar = 0;
  wire rx_valid_in, tx_valid_out, tx_ready_in, prt_valid_out, ram_we_out, init_out;
  wire err_reset_out, stop_motion_out, test_mode_out, busy_out;
  wire [7:0] rx_data_in, tx_data_out, prt_data_out, ram_addr_out, ram_wdata_out;
  wire [2:0] report_out;
  wire [11:0] rom_addr_out;
  pstd_selftest i_pstd_selftest (.clk_in, .rst_n_in, .selftest_start_in, .printer_idle_in,
    .error_pending_in, .wheel_info_in, .aux_ram_bad_in, .aux_rom_bad_in, .parity_bit_in,
    .rx_valid_in, .rx_data_in, .tx_valid_out, .tx_data_out, .tx_ready_in, .prt_valid_out,
    .prt_data_out, .prt_ready_in(1'b1), .report_out, .rom_addr_out, .rom_data_in, .ram_addr_out,
    .ram_we_out, .ram_wdata_out, .ram_rdata_in, .init_out, .err_reset_out, .stop_motion_out,
    .test_mode_out, .busy_out);
  pstd_host_model i_host (.clk_in, .rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in),
    .tx_valid_in(tx_valid_out), .tx_data_in(tx_data_out), .tx_ready_out(tx_ready_in));
  // ****************************************
  // Clock, memories and print monitor
  // ****************************************
  always #4 clk_in = ~clk_in;
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Write-first memories; faults at ROM 005, RAM 40 bit 0
  always @(posedge clk_in)
  begin
    rom_data_in <= (rom_bad && rom_addr_out == 12'h005) ? 8'h01 : 8'h00;
    ram_rdata_in <= (ram_we_out === 1'b1 ? ram_wdata_out : mem[ram_addr_out]) &
      ~{7'h00, ram_bad && ram_addr_out == 8'h40};
    if (ram_we_out === 1'b1)
      mem[ram_addr_out] <= ram_wdata_out;
    if (prt_valid_out === 1'b1)
    begin
      nchar <= nchar + ((prt_data_out inside {[`PSTD_CH_SP:`PSTD_CH_TOP]}) ? 1 : 0);
      last2 <= last1;
      last1 <= prt_data_out;
    end
    if (report_out !== 3'h0)
      reps.push_back(report_out);
  end
  task chk8(input logic [7:0] got, input logic [7:0] want);
    check_count++;
    if (got !== want)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Bounded waits
  task reply(output logic [7:0] r);
    for (int i = 0; i < 200000 && i_host.got.size() == 0; i++)
      @(posedge clk_in);
    if (i_host.got.size() == 0)
    begin
      chk8(8'hEE, 8'h00);
      give_verdict();
    end
    r = i_host.got.pop_front();
  endtask
  task wait_free();
    repeat (2) @(posedge clk_in);
    for (int i = 0; i < 200000 && busy_out === 1'b1; i++)
      @(posedge clk_in);
    if (busy_out !== 1'b0)
    begin
      miscompares++;
      give_verdict();
    end
  endtask
  task cmd(input logic [7:0] c);
    i_host.send(`PSTD_CH_ESC);
    i_host.send(`PSTD_CH_SUB);
    i_host.send(c);
    i_host.idle();
  endtask
  task tbyte(input logic [7:0] c);
    i_host.send(c);
    i_host.idle();
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {selftest_start_in, printer_idle_in, error_pending_in, rom_bad, ram_bad} = 5'h00;
    {aux_ram_bad_in, aux_rom_bad_in, parity_bit_in, wheel_info_in} = 11'h000;
    foreach (mem[k]) mem[k] = 8'(rnd());
    keep = mem[8'h10];
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      wheel_info_in <= (k == 0) ? 8'h07 : 8'(rnd());
      {printer_idle_in, parity_bit_in, error_pending_in, aux_ram_bad_in, aux_rom_bad_in} <= 5'(rnd());
      cmd(`PSTD_CH_STAT);
      reply(b);
      chk8(b, {parity_bit_in, 1'b0, printer_idle_in, 3'h0, wheel_info_in[2:0] == 3'h7, 1'b0});
    end
    {printer_idle_in, rom_bad, ram_bad} <= 3'h7;
    wait_free();
    cmd(`PSTD_CH_SO);
    reply(b);
    chk8(b, {parity_bit_in, 4'h2, 1'b1, aux_rom_bad_in, aux_ram_bad_in});
    wait_free();
    selftest_start_in <= 1'b1;
    @(posedge clk_in);
    selftest_start_in <= 1'b0;
    wait_free();
    chk8({5'h00, reps[0]}, 8'h01);
    chk8({5'h00, reps[1]}, 8'h03);
    chk8({5'h00, reps[2]}, 8'h05);
    chk8(8'(nchar), 8'h00);
    {rom_bad, ram_bad} <= 2'h0;
    mem[8'h22] = wheel_info_in;
    cmd(`PSTD_CH_ENQ);
    reply(b);
    chk8(b, `PSTD_CH_SO);
    i_host.send(`PSTD_CH_RD);
    tbyte(`PSTD_WHEEL_ADDR);
    reply(b);
    chk8(b, `PSTD_CH_STX);
    reply(b);
    chk8(b, wheel_info_in);
    i_host.send(`PSTD_CH_RD);
    tbyte(8'h10);
    reply(b);
    reply(b);
    chk8(b, keep);
    tbyte(8'h5A);
    nchar = 0;
    tbyte(`PSTD_CH_TB);
    reply(b);
    chk8(b, `PSTD_CH_ACK);
    chk8(8'(nchar), `PSTD_LINE_CHARS);
    tbyte(`PSTD_CH_TC);
    repeat (50) @(posedge clk_in);
    tbyte(`PSTD_CH_TD);
    reply(b);
    chk8(b, `PSTD_CH_ACK);
    chk8(last2, `PSTD_CH_CR);
    chk8(last1, `PSTD_CH_LF);
    tbyte(`PSTD_CH_DEL);
    repeat (4) @(posedge clk_in);
    chk8({7'h00, test_mode_out}, 8'h00);
    wait_free();
    error_pending_in <= 1'b1;
    tbyte(8'h00);
    cmd(`PSTD_CH_INIT);
    wait_free();
    cmd(`PSTD_CH_ERST);
    repeat (2) @(posedge clk_in);
    chk8({7'h00, err_reset_out}, 8'h01);
    give_verdict();
  end
endmodule
bind pstd_selftest pstd_selftest_properties i_chk (.clk_in, .rst_n_in, .rx_valid_in, .rx_data_in,
  .wheel_info_in, .tx_ready_in, .tx_valid_out, .tx_data_out, .prt_valid_out, .prt_data_out,
  .report_out, .init_out, .err_reset_out, .test_mode_out);
